// *** include/sync_cfg_pkg.sv ***
// Constants and types for the sync and configuration handshake block
package sync_cfg_pkg;
    localparam int DATA_W = 16;
    localparam int CLK_PERIOD_NS = 100;
    // Completion pulse length in master clock cycles
    localparam logic [3:0] DONE_PULSE_CYCLES = 4'h8;
    // Filter settling time in ns, and derived cycle count (rounded up)
    localparam int SETTLE_NS = 3200;
    localparam int SETTLE_CYC_I = (SETTLE_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam logic [7:0] SETTLE_CYCLES = SETTLE_CYC_I[7:0];
    localparam logic [3:0] SEQ_RESET = 4'h0;
    localparam logic FLAG_RESET = 1'b1;
    localparam logic [DATA_W-1:0] BUS_RESET = 16'h0000;

    typedef enum logic [1:0] {
        MODE_PROC = 2'b00,
        MODE_EPROM = 2'b01,
        MODE_ROM = 2'b10
    } bootMode_t;

    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_RAISED = 2'b01,
        HS_PULSE = 2'b10
    } hsState_t;
endpackage : sync_cfg_pkg

// *** hdl/bus_read_latch.sv ***
// Parallel port read-data and write-capture registers
`timescale 1ns/100ps
module bus_read_latch
    import sync_cfg_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic csFall,
    input wire logic csRise,
    input wire logic readNotWrite,
    input wire logic register_select,
    input wire logic [DATA_W-1:0] convData,
    input wire logic [DATA_W-1:0] statusData,
    input wire logic [DATA_W-1:0] busIn,
    output logic [DATA_W-1:0] busOut,
    output logic [DATA_W-1:0] writeData,
    output logic writeIsInstr,
    output logic writeStrobe
);
    logic [DATA_W-1:0] busOut_r, busOut_nxt;
    logic [DATA_W-1:0] wData_r, wData_nxt;
    logic wInstr_r, wInstr_nxt, wStb_r, wStb_nxt;

    always_comb begin
        busOut_nxt = busOut_r;
        wData_nxt = wData_r;
        wInstr_nxt = wInstr_r;
        wStb_nxt = 1'b0;
        if (csFall && readNotWrite) begin
            busOut_nxt = register_select ? statusData : convData;
        end
        if (csRise && !readNotWrite) begin
            wData_nxt = busIn;
            wInstr_nxt = register_select;
            wStb_nxt = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            busOut_r <= BUS_RESET;
            wData_r <= BUS_RESET;
            wInstr_r <= 1'b0;
            wStb_r <= 1'b0;
        end else begin
            busOut_r <= busOut_nxt;
            wData_r <= wData_nxt;
            wInstr_r <= wInstr_nxt;
            wStb_r <= wStb_nxt;
        end
    end

    assign busOut = busOut_r;
    assign writeData = wData_r;
    assign writeIsInstr = wInstr_r;
    assign writeStrobe = wStb_r;

    write_capture_a: assert property (@(posedge sys_clk)
        disable iff (!resetn)
        csRise && !readNotWrite |=> writeStrobe && writeData == $past(busIn))
        else $error("write data not captured");
endmodule : bus_read_latch

// *** hdl/sync_cfg_handshake.sv ***
// Sync input, configuration handshake output and parallel port control
// Functional notes
// - While sync is high, sequencer counter held at zero, core held reset.
// - Devices sharing clock and sync pulse sample and update together.
// - After sync falls, conversions resume; data valid after settling time.
// - EPROM mode: handshake driven low enables EPROM, resets its address.
// - Processor mode: handshake is an active-high interrupt request.
// - Processor mode: handshake rises after reset and configuration restart.
// - Processor mode: handshake rises again after successful configuration.
// - Processor mode: handshake cleared once frame sync sampled high.
// - ROM mode: handshake pulses high eight clocks on successful config.
// - Chip select fall on a read enables bus drivers with conversion or status data.
// - Chip select rise on a write latches bus as data or instruction; host holds it.
`timescale 1ns/100ps
module sync_cfg_handshake
    import sync_cfg_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic syncIn,
    input wire logic [1:0] bootMode,
    input wire logic config_restart_n,
    input wire logic configDone,
    input wire logic frame_sync_in,
    input wire logic chipSelectN,
    input wire logic readNotWrite,
    input wire logic register_select,
    input wire logic [DATA_W-1:0] convData,
    input wire logic [DATA_W-1:0] statusData,
    input wire logic [DATA_W-1:0] busIn,
    output logic [DATA_W-1:0] busOut,
    output logic busOe,
    output logic [DATA_W-1:0] writeData,
    output logic writeIsInstr,
    output logic writeStrobe,
    output logic cfg_handshake_flag,
    output logic [3:0] seqCount,
    output logic coreReset,
    output logic dataValid
);
    ////////////////////////////////////////////////////////////////////////
    // Sync, sequencer and settling
    logic syncHigh_r, syncHigh_nxt;
    logic [3:0] seq_r, seq_nxt;
    logic [7:0] settle_r, settle_nxt;
    logic valid_r, valid_nxt;

    always_comb begin
        syncHigh_nxt = syncIn;
        seq_nxt = seq_r + 4'h1;
        settle_nxt = settle_r;
        valid_nxt = valid_r;
        if (syncIn) begin
            seq_nxt = SEQ_RESET;
            settle_nxt = 8'h00;
            valid_nxt = 1'b0;
        end else if (settle_r != SETTLE_CYCLES) begin
            settle_nxt = settle_r + 8'h01;
        end else begin
            valid_nxt = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            syncHigh_r <= 1'b0;
            seq_r <= SEQ_RESET;
            settle_r <= 8'h00;
            valid_r <= 1'b0;
        end else begin
            syncHigh_r <= syncHigh_nxt;
            seq_r <= seq_nxt;
            settle_r <= settle_nxt;
            valid_r <= valid_nxt;
        end
    end

    assign seqCount = seq_r;
    assign coreReset = syncHigh_r;
    assign dataValid = valid_r;

    sync_reset_a: assert property (@(posedge sys_clk)
        disable iff (!resetn)
        syncIn |=> seqCount == 4'h0 && coreReset && !dataValid)
        else $error("sync did not reset sequencer");
    seq_lockstep_a: assert property (@(posedge sys_clk)
        disable iff (!resetn)
        syncIn ##1 !syncIn |=> seqCount == 4'h1)
        else $error("sequencer did not restart from zero");
    // Valid stays low for the whole settling span after sync release
    settle_wait_a: assert property (@(posedge sys_clk)
        disable iff (!resetn)
        $fell(coreReset) |-> !dataValid[*8] ##1 !dataValid[*8]
        ##1 !dataValid[*8] ##1 !dataValid[*8])
        else $error("data valid before settling");

    ////////////////////////////////////////////////////////////////////////
    // Configuration handshake
    hsState_t hs_r, hs_nxt;
    logic [3:0] pulse_r, pulse_nxt;
    logic flag_r, flag_nxt;
    logic restartD_r, restartD_nxt;

    always_comb begin
        hs_nxt = hs_r;
        pulse_nxt = pulse_r;
        flag_nxt = flag_r;
        restartD_nxt = config_restart_n;
        case (bootMode)
            MODE_EPROM: begin
                flag_nxt = configDone;
                hs_nxt = HS_IDLE;
            end
            MODE_ROM: begin
                case (hs_r)
                    HS_PULSE: begin
                        if (pulse_r == DONE_PULSE_CYCLES - 4'h1) begin
                            flag_nxt = 1'b0;
                            hs_nxt = HS_IDLE;
                        end
                        pulse_nxt = pulse_r + 4'h1;
                    end
                    default: begin
                        flag_nxt = 1'b0;
                        if (configDone) begin
                            flag_nxt = 1'b1;
                            pulse_nxt = 4'h0;
                            hs_nxt = HS_PULSE;
                        end
                    end
                endcase
            end
            default: begin
                hs_nxt = HS_IDLE;
                if (restartD_r && !config_restart_n) begin
                    flag_nxt = 1'b1;
                end else if (configDone) begin
                    flag_nxt = 1'b1;
                end else if (frame_sync_in) begin
                    flag_nxt = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            hs_r <= HS_IDLE;
            pulse_r <= 4'h0;
            flag_r <= FLAG_RESET;
            restartD_r <= 1'b1;
        end else begin
            hs_r <= hs_nxt;
            pulse_r <= pulse_nxt;
            flag_r <= flag_nxt;
            restartD_r <= restartD_nxt;
        end
    end

    assign cfg_handshake_flag = flag_r;

    eprom_enable_a: assert property (@(posedge sys_clk)
        disable iff (!resetn)
        bootMode == MODE_EPROM && !configDone |=> !cfg_handshake_flag)
        else $error("EPROM not enabled");
    proc_done_a: assert property (@(posedge sys_clk)
        disable iff (!resetn)
        bootMode == MODE_PROC && $past(bootMode) == MODE_PROC && configDone
        |=> cfg_handshake_flag)
        else $error("completion not signalled");
    proc_clear_a: assert property (@(posedge sys_clk)
        disable iff (!resetn)
        bootMode == MODE_PROC && frame_sync_in && !configDone
        && !(restartD_r && !config_restart_n) |=> !cfg_handshake_flag)
        else $error("frame sync did not clear");
    rom_pulse_a: assert property (@(posedge sys_clk)
        disable iff (!resetn)
        bootMode == MODE_ROM && hs_r == HS_IDLE && configDone
        |=> cfg_handshake_flag[*8] ##1 !cfg_handshake_flag)
        else $error("ROM pulse not eight cycles");

    ////////////////////////////////////////////////////////////////////////
    // Parallel host port
    logic csN_r, csN_nxt;
    logic oe_r, oe_nxt;

    always_comb begin
        csN_nxt = chipSelectN;
        oe_nxt = !chipSelectN && readNotWrite;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            csN_r <= 1'b1;
            oe_r <= 1'b0;
        end else begin
            csN_r <= csN_nxt;
            oe_r <= oe_nxt;
        end
    end

    assign busOe = oe_r;

    bus_read_latch u_bus_read_latch (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .csFall(csN_r && !chipSelectN),
        .csRise(!csN_r && chipSelectN),
        .readNotWrite(readNotWrite),
        .register_select(register_select),
        .convData(convData),
        .statusData(statusData),
        .busIn(busIn),
        .busOut(busOut),
        .writeData(writeData),
        .writeIsInstr(writeIsInstr),
        .writeStrobe(writeStrobe)
    );

    read_drive_a: assert property (@(posedge sys_clk)
        disable iff (!resetn)
        csN_r && !chipSelectN && readNotWrite |=> busOe
        && busOut == ($past(register_select) ? $past(statusData)
        : $past(convData)))
        else $error("read data not driven");
endmodule : sync_cfg_handshake

// *** test/host_model.sv ***
// Host bus master model for the parallel port
`timescale 1ns/100ps
module host_model
    import sync_cfg_pkg::*;
(
    input wire logic sys_clk,
    input wire logic [DATA_W-1:0] busOut,
    input wire logic busOe,
    output logic chipSelectN,
    output logic readNotWrite,
    output logic register_select,
    output logic [DATA_W-1:0] busIn
);
    initial begin
        chipSelectN = 1'b1;
        readNotWrite = 1'b1;
        register_select = 1'b0;
        busIn = 16'h5a5a;
    end
    // Released bus shows the inverse of its last value
    task automatic busRead(input logic rs, output logic [DATA_W-1:0] d,
                           output logic oe);
        @(negedge sys_clk);
        busIn = ~busIn;
        readNotWrite = 1'b1;
        register_select = rs;
        chipSelectN = 1'b0;
        @(negedge sys_clk);
        d = busOut;
        oe = busOe;
        chipSelectN = 1'b1;
    endtask : busRead
    task automatic busWrite(input logic rs, input logic [DATA_W-1:0] d);
        @(negedge sys_clk);
        readNotWrite = 1'b0;
        register_select = rs;
        busIn = d;
        chipSelectN = 1'b0;
        @(negedge sys_clk);
        chipSelectN = 1'b1;
        @(negedge sys_clk);
    endtask : busWrite
endmodule : host_model

// *** test/test_sync_cfg_handshake.sv ***
// Self-checking bench for the sync and handshake block
`timescale 1ns/100ps
module test_sync_cfg_handshake;
    import sync_cfg_pkg::*;
    logic sys_clk, resetn, syncIn, config_restart_n, configDone;
    logic frame_sync_in, chipSelectN, readNotWrite, register_select;
    logic [1:0] bootMode;
    logic [DATA_W-1:0] convData, statusData, busIn, busOut, writeData;
    logic busOe, writeIsInstr, writeStrobe, cfg_handshake_flag;
    logic coreReset, dataValid, oe, e;
    logic [3:0] seqCount;
    logic [DATA_W-1:0] rd, w;
    logic [DATA_W-1:0] expQ[$];
    int mismatches, comparisons, n;

    sync_cfg_handshake u_sync_cfg_handshake (.sys_clk, .resetn, .syncIn,
        .bootMode, .config_restart_n, .configDone, .frame_sync_in,
        .chipSelectN, .readNotWrite, .register_select, .convData,
        .statusData, .busIn, .busOut, .busOe, .writeData, .writeIsInstr,
        .writeStrobe, .cfg_handshake_flag, .seqCount, .coreReset,
        .dataValid);
    host_model host (.sys_clk, .busOut, .busOe, .chipSelectN,
        .readNotWrite, .register_select, .busIn);

    initial begin
        sys_clk = 1'b0;
        forever #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;
    end

    task automatic checkBus(input logic [DATA_W-1:0] x, g);
        comparisons++;
        if (g !== x) begin
            mismatches++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, x, g);
        end
    endtask : checkBus
    task automatic checkBit(input logic x, g);
        checkBus({15'h0000, x}, {15'h0000, g});
    endtask : checkBit
    task automatic tick(input int k);
        repeat (k) @(negedge sys_clk);
    endtask : tick
    task automatic conclude();
        $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude

    initial begin
        #(CLK_PERIOD_NS * 3000);
        mismatches++;
        conclude();
    end

    initial begin
        mismatches = 0;
        comparisons = 0;
        {resetn, syncIn, configDone, frame_sync_in} = 4'h0;
        config_restart_n = 1'b1;
        bootMode = MODE_PROC;
        convData = 16'h0000;
        statusData = 16'h0000;
        void'($urandom(32'h91de));
        tick(8);
        checkBit(1'b1, cfg_handshake_flag);
        checkBit(1'b0, busOe);
        resetn = 1'b1;
        // Processor load handshake
        frame_sync_in = 1'b1;
        tick(1);
        checkBit(1'b0, cfg_handshake_flag);
        frame_sync_in = 1'b0;
        config_restart_n = 1'b0;
        tick(1);
        checkBit(1'b1, cfg_handshake_flag);
        config_restart_n = 1'b1;
        frame_sync_in = 1'b1;
        tick(2);
        checkBit(1'b0, cfg_handshake_flag);
        configDone = 1'b1;
        tick(1);
        checkBit(1'b1, cfg_handshake_flag);
        {configDone, frame_sync_in} = 2'b00;
        tick(2);
        checkBit(1'b1, cfg_handshake_flag);
        // Sync pulses of several lengths, spaced by full settling
        for (int len = 1; len <= 3; len++) begin
            syncIn = 1'b1;
            repeat (len) begin
                tick(1);
                checkBus({12'h000, SEQ_RESET}, {12'h000, seqCount});
                checkBit(1'b1, coreReset);
                checkBit(1'b0, dataValid);
            end
            syncIn = 1'b0;
            tick(1);
            checkBus(16'h0001, {12'h000, seqCount});
            checkBit(1'b0, coreReset);
            n = 1;
            while (dataValid !== 1'b1 && n < 80) begin
                tick(1);
                n++;
            end
            checkBit(1'b1, n >= SETTLE_CYCLES && n <= SETTLE_CYCLES + 2);
        end
        // EPROM mode follows completion one edge later
        bootMode = MODE_EPROM;
        repeat (16) begin
            e = 1'($urandom);
            configDone = e;
            tick(1);
            checkBit(e, cfg_handshake_flag);
        end
        configDone = 1'b0;
        tick(1);
        // ROM mode pulse, with a retrigger attempt mid-pulse
        bootMode = MODE_ROM;
        configDone = 1'b1;
        n = 0;
        for (int i = 0; i < 12; i++) begin
            tick(1);
            configDone = (i == 3);
            if (cfg_handshake_flag === 1'b1) n++;
        end
        checkBus(16'(DONE_PULSE_CYCLES), 16'(n));
        checkBit(1'b0, cfg_handshake_flag);
        // Parallel reads and writes back to back
        for (int i = 0; i < 8; i++) begin
            convData = 16'($urandom);
            statusData = 16'($urandom);
            w = 16'($urandom);
            expQ.push_back(i[0] ? statusData : convData);
            expQ.push_back(w);
            host.busRead(i[0], rd, oe);
            checkBit(1'b1, oe);
            checkBus(expQ.pop_front(), rd);
            tick(1);
            checkBit(1'b0, busOe);
            host.busWrite(i[1], w);
            checkBus(expQ.pop_front(), writeData);
            checkBit(i[1], writeIsInstr);
            checkBit(1'b1, writeStrobe);
            tick(1);
            checkBit(1'b0, writeStrobe);
        end
        conclude();
    end
endmodule : test_sync_cfg_handshake
